/* File: hdl/servo_io_defines.svh */
// constants for the servo sequence i/o block: register offsets, field codes, reset values, timing
// assumes a 250 MHz ref_clk and a word-indexed plain register port
`ifndef SERVO_IO_DEFINES_SVH
`define SERVO_IO_DEFINES_SVH

// ==========================================================
// timing
`define CLK_MHZ 250
`define ERR_CLEAR_MIN_US 2000
`define ALARM_RESET_MIN_US 120000
`define ERR_CLEAR_CYCLES (`ERR_CLEAR_MIN_US * `CLK_MHZ)
`define ALARM_RESET_CYCLES (`ALARM_RESET_MIN_US * `CLK_MHZ)

// ==========================================================
// register offsets (word index)
`define REG_MODE 4'h0
`define REG_GEAR_NUM_ONE 4'h1
`define REG_GEAR_NUM_TWO 4'h2
`define REG_PULSE_CFG 4'h3
`define REG_AUX_SEL 4'h4
`define REG_ENC_DIV_NUM 4'h5
`define REG_ENC_DIV_DEN 4'h6
`define REG_INPOS_WINDOW 4'h7
`define REG_ROT_THRESH 4'h8
`define REG_ALARM 4'h9
`define REG_STATUS 4'hA
`define REG_DEVIATION 4'hB
`define REG_SPEED 4'hC

// ==========================================================
// field positions and codes
`define MODE_SPEED_BIT 0
`define MAIN_POWER_BIT 1
`define STOP_DYN_BRAKE_BIT 0
`define STOP_CLEAR_BIT 1
`define PULSE_SRC_BIT 0
`define PULSE_INH_EN_BIT 1
`define PULSE_FMT_LSB 2
`define ALARM_PERM_BIT 31

// ==========================================================
// reset values
`define GEAR_NUM_RESET 16'h0001
`define ENC_DIV_RESET 16'h0001
`define INPOS_WINDOW_RESET 16'h000A
`define ROT_THRESH_RESET 16'h0032

`endif

/* File: hdl/servo_io_pkg.sv */
// types shared by the servo sequence i/o block
// assumes servo_io_defines.svh is included alongside
`default_nettype none
package servo_io_pkg;

  typedef enum logic [1:0] {
    fmt_rev_fwd,
    fmt_pulse_dir,
    fmt_quadrature,
    fmt_reserved
  } pulse_fmt_e;

  typedef enum logic [1:0] {
    st_servo_off,
    st_servo_on,
    st_alarm
  } run_state_e;

  // discrete sequence inputs from the host
  typedef struct packed {
    logic run_in;
    logic alarm_reset_in;
    logic position_error_clear_in;
    logic gear_ratio_select_in;
    logic pulse_inhibit_in;
    logic preset_speed_bit0_in;
    logic preset_speed_bit1_in;
    logic preset_speed_bit2_in;
  } seq_in_s;

  // command pulse pins, both sources
  typedef struct packed {
    logic reverse_pulse_diff_pos;
    logic forward_pulse_diff_pos;
    logic reverse_pulse_oc;
    logic forward_pulse_oc;
  } pulse_in_s;

  // encoder feedback from the motor
  typedef struct packed {
    logic enc_a;
    logic enc_b;
    logic enc_z;
  } enc_in_s;

  // outputs on the control connector
  typedef struct packed {
    logic brake_release_out;
    logic servo_ready_out;
    logic fault_out_n;
    logic in_position_out;
    logic rotation_detect_out;
    logic aux_output_one;
    logic aux_output_two;
    logic z_index_oc_out;
    logic enc_a_pos;
    logic enc_a_neg;
    logic enc_b_pos;
    logic enc_b_neg;
    logic enc_z_pos;
    logic enc_z_neg;
    logic motor_power_en;
    logic dynamic_brake_en;
  } seq_out_s;

  // register port
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage
`default_nettype wire

/* File: hdl/servo_sequence_io_control.sv */
// sequence i/o logic of the servo drive control connector
// assumes pins are asynchronous to ref_clk; alarms and motor speed come from the drive core
//
// Design decisions made here: strobed register access and the register offsets.
`include "servo_io_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module servo_sequence_io_control #(
  parameter int unsigned ERR_CLEAR_CYC = `ERR_CLEAR_CYCLES,
  parameter int unsigned ALARM_RESET_CYC = `ALARM_RESET_CYCLES,
  parameter int unsigned BRAKE_DELAY_CYC = 1000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire servo_io_pkg::reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  // connector pins
  input wire servo_io_pkg::seq_in_s seq_in,
  input wire servo_io_pkg::pulse_in_s pulse_in,
  input wire servo_io_pkg::enc_in_s enc_in,
  // drive core status
  input wire logic [31:0] alarm_src,
  input wire logic [15:0] motor_speed,
  output servo_io_pkg::seq_out_s seq_out,
  output logic [2:0] preset_speed_sel
);
  import servo_io_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [23:0] seq_sync0;
    logic [23:0] seq_sync1;
    logic [23:0] seq_sync2;
    seq_in_s seq;
    logic [11:0] pin_sync0;
    logic [11:0] pin_sync1;
    logic [11:0] pin_sync2;
    logic [3:0] pin;
    logic [2:0] enc;
    logic [31:0] clr_cnt;
    logic [31:0] rst_cnt;
    logic rst_done;
    run_state_e state;
    logic [31:0] brake_cnt;
    logic signed [31:0] deviation;
    logic [31:0] alarms;
    logic speed_mode;
    logic main_power;
    logic [15:0] gear_one;
    logic [15:0] gear_two;
    logic [1:0] stop_sel;
    logic pulse_src;
    logic pulse_inh_en;
    pulse_fmt_e pulse_fmt;
    logic [3:0] aux_one_sel;
    logic [3:0] aux_two_sel;
    logic [15:0] div_num;
    logic [15:0] div_den;
    logic [15:0] inpos_win;
    logic [15:0] rot_thresh;
    logic [16:0] div_acc;
    logic [1:0] out_phase;
    seq_out_s out;
    logic [2:0] speed_sel;
    logic [31:0] rdata;
  } state_s;

  state_s q_r;
  state_s q_nxt;

  // three-stage sync: a bit counts once stages two and three agree
  function automatic logic filt(input logic s1, input logic s2, input logic held);
    filt = (s1 == s2) ? s2 : held;
  endfunction

  function automatic logic [1:0] gray_step(input logic [1:0] p, input logic up);
    logic [1:0] n;
    n = p;
    case ({up, p})
      3'b1_00: n = 2'b01;
      3'b1_01: n = 2'b11;
      3'b1_11: n = 2'b10;
      3'b1_10: n = 2'b00;
      3'b0_00: n = 2'b10;
      3'b0_10: n = 2'b11;
      3'b0_11: n = 2'b01;
      3'b0_01: n = 2'b00;
      default: n = p;
    endcase
    gray_step = n;
  endfunction

  function automatic logic [31:0] absval(input logic signed [31:0] v);
    absval = v[31] ? 32'(-v) : 32'(v);
  endfunction

  logic [7:0] seq_raw;
  logic [7:0] seq_f;
  logic [3:0] pin_raw;
  logic [3:0] pin_f;
  logic [2:0] enc_f;
  logic [1:0] ab_new;
  logic [1:0] ab_old;
  logic pa;
  logic pb;
  logic pa_old;
  logic pb_old;
  logic step;
  logic up;
  logic [15:0] gear;
  logic clr_now;
  logic alarm_any;
  logic [7:0] status;
  logic [16:0] acc;
  logic enc_step;
  logic enc_up;
  logic [1:0] ea;
  logic [1:0] eo;

  always_comb begin
    q_nxt = q_r;
    seq_raw = seq_in;
    pin_raw = pulse_in;
    // ==========================================================
    // input synchronisation and filtering
    q_nxt.seq_sync0 = {16'h0000, seq_raw};
    q_nxt.seq_sync1 = q_r.seq_sync0;
    q_nxt.seq_sync2 = q_r.seq_sync1;
    for (int i = 0; i < 8; i++) begin
      seq_f[i] = filt(q_r.seq_sync1[i], q_r.seq_sync2[i], q_r.seq[i]);
    end
    q_nxt.seq = seq_f;
    q_nxt.pin_sync0 = {5'h00, enc_in, pin_raw};
    q_nxt.pin_sync1 = q_r.pin_sync0;
    q_nxt.pin_sync2 = q_r.pin_sync1;
    for (int i = 0; i < 4; i++) begin
      pin_f[i] = filt(q_r.pin_sync1[i], q_r.pin_sync2[i], q_r.pin[i]);
    end
    for (int i = 0; i < 3; i++) begin
      enc_f[i] = filt(q_r.pin_sync1[4 + i], q_r.pin_sync2[4 + i], q_r.enc[i]);
    end
    q_nxt.pin = pin_f;
    q_nxt.enc = enc_f;

    // ==========================================================
    // command pulse decode
    pa = q_r.pulse_src ? pin_f[3] : pin_f[1];
    pb = q_r.pulse_src ? pin_f[2] : pin_f[0];
    pa_old = q_r.pulse_src ? q_r.pin[3] : q_r.pin[1];
    pb_old = q_r.pulse_src ? q_r.pin[2] : q_r.pin[0];
    step = 1'b0;
    up = 1'b0;
    ab_new = {pa, pb};
    ab_old = {pa_old, pb_old};
    case (q_r.pulse_fmt)
      fmt_rev_fwd: begin
        if (pb && !pb_old) begin
          step = 1'b1;
          up = 1'b1;
        end else if (pa && !pa_old) begin
          step = 1'b1;
        end
      end
      fmt_pulse_dir: begin
        step = pa && !pa_old;
        up = pb;
      end
      fmt_quadrature: begin
        step = ab_new != ab_old && ab_new != ~ab_old;
        up = gray_step(ab_old, 1'b1) == ab_new;
      end
      default: step = 1'b0;
    endcase
    gear = q_r.seq.gear_ratio_select_in ? q_r.gear_two : q_r.gear_one;
    if (q_r.pulse_inh_en == 1'b0 && !q_r.seq.pulse_inhibit_in) begin
      step = 1'b0;
    end
    if (q_r.speed_mode || q_r.state != st_servo_on) begin
      step = 1'b0;
    end
    if (step) begin
      q_nxt.deviation = up ? q_r.deviation + 32'(gear) : q_r.deviation - 32'(gear);
    end

    // ==========================================================
    // minimum width timers
    q_nxt.clr_cnt = q_r.seq.position_error_clear_in ?
      ((q_r.clr_cnt < ERR_CLEAR_CYC) ? q_r.clr_cnt + 32'h1 : q_r.clr_cnt) : 32'h0;
    clr_now = q_r.clr_cnt >= ERR_CLEAR_CYC;
    q_nxt.rst_cnt = q_r.seq.alarm_reset_in ?
      ((q_r.rst_cnt < ALARM_RESET_CYC) ? q_r.rst_cnt + 32'h1 : q_r.rst_cnt) : 32'h0;
    q_nxt.rst_done = q_r.rst_cnt >= ALARM_RESET_CYC;

    // ==========================================================
    // alarms: new alarms win over a reset in the same cycle
    q_nxt.alarms = q_r.alarms | alarm_src;
    if (q_nxt.rst_done && !q_r.rst_done) begin
      q_nxt.alarms = (q_r.alarms & {1'b1, 31'h0}) | alarm_src;
      q_nxt.deviation = 32'sh0;
    end
    alarm_any = |q_r.alarms;

    // ==========================================================
    // run sequence
    case (q_r.state)
      st_servo_off: begin
        if (alarm_any) begin
          q_nxt.state = st_alarm;
        end else if (q_r.seq.run_in && q_r.main_power) begin
          q_nxt.state = st_servo_on;
        end
      end
      st_servo_on: begin
        if (alarm_any || !q_r.seq.run_in || !q_r.main_power) begin
          q_nxt.state = alarm_any ? st_alarm : st_servo_off;
          if (q_r.stop_sel[`STOP_CLEAR_BIT]) begin
            q_nxt.deviation = 32'sh0;
          end
        end
      end
      st_alarm: begin
        if (!alarm_any) begin
          q_nxt.state = st_servo_off;
        end
      end
      default: q_nxt.state = st_servo_off;
    endcase
    if (clr_now && !q_r.speed_mode) begin
      q_nxt.deviation = 32'sh0;
    end
    q_nxt.out.motor_power_en = q_nxt.state == st_servo_on;
    q_nxt.out.dynamic_brake_en = q_nxt.state != st_servo_on &&
      q_r.stop_sel[`STOP_DYN_BRAKE_BIT];
    // brake releases after power is on, engages at once on stop
    if (q_r.state == st_servo_on) begin
      q_nxt.brake_cnt = (q_r.brake_cnt < BRAKE_DELAY_CYC) ? q_r.brake_cnt + 32'h1 : q_r.brake_cnt;
    end else begin
      q_nxt.brake_cnt = 32'h0;
    end
    q_nxt.out.brake_release_out = q_nxt.state == st_servo_on &&
      q_r.brake_cnt >= BRAKE_DELAY_CYC;

    // ==========================================================
    // status outputs
    q_nxt.out.servo_ready_out = q_r.main_power && !alarm_any;
    q_nxt.out.fault_out_n = !alarm_any;
    q_nxt.out.in_position_out = !q_r.speed_mode &&
      absval(q_r.deviation) <= 32'(q_r.inpos_win);
    q_nxt.out.rotation_detect_out = q_r.speed_mode && motor_speed > q_r.rot_thresh;
    q_nxt.speed_sel = q_r.speed_mode ? {q_r.seq.preset_speed_bit2_in,
      q_r.seq.preset_speed_bit1_in, q_r.seq.preset_speed_bit0_in} : 3'h0;
    status = {1'b0, q_r.out.dynamic_brake_en, q_r.out.motor_power_en,
      q_r.out.rotation_detect_out, q_r.out.in_position_out, alarm_any,
      q_r.out.servo_ready_out, q_r.out.brake_release_out};
    q_nxt.out.aux_output_one = status[q_r.aux_one_sel[2:0]];
    q_nxt.out.aux_output_two = status[q_r.aux_two_sel[2:0]];

    // ==========================================================
    // encoder divider: forwards num of every den encoder steps
    ea = q_r.enc[2:1];
    eo = {enc_f[2], enc_f[1]};
    enc_step = ea != eo && ea != ~eo;
    enc_up = gray_step(ea, 1'b1) == eo;
    acc = q_r.div_acc;
    if (enc_step) begin
      acc = q_r.div_acc + {1'b0, q_r.div_num};
      if (acc >= {1'b0, q_r.div_den}) begin
        acc = acc - {1'b0, q_r.div_den};
        q_nxt.out_phase = gray_step(q_r.out_phase, enc_up);
      end
    end
    q_nxt.div_acc = acc;
    q_nxt.out.enc_a_pos = q_r.out_phase[1];
    q_nxt.out.enc_a_neg = !q_r.out_phase[1];
    q_nxt.out.enc_b_pos = q_r.out_phase[0];
    q_nxt.out.enc_b_neg = !q_r.out_phase[0];
    q_nxt.out.enc_z_pos = q_r.enc[0];
    q_nxt.out.enc_z_neg = !q_r.enc[0];
    q_nxt.out.z_index_oc_out = q_r.enc[0];

    // ==========================================================
    // register port
    if (reg_req.wr) begin
      case (reg_req.addr)
        `REG_MODE: begin
          q_nxt.speed_mode = reg_req.wdata[`MODE_SPEED_BIT];
          q_nxt.main_power = reg_req.wdata[`MAIN_POWER_BIT];
          q_nxt.stop_sel = reg_req.wdata[9:8];
        end
        `REG_GEAR_NUM_ONE: q_nxt.gear_one = reg_req.wdata[15:0];
        `REG_GEAR_NUM_TWO: q_nxt.gear_two = reg_req.wdata[15:0];
        `REG_PULSE_CFG: begin
          q_nxt.pulse_src = reg_req.wdata[`PULSE_SRC_BIT];
          q_nxt.pulse_inh_en = reg_req.wdata[`PULSE_INH_EN_BIT];
          q_nxt.pulse_fmt = pulse_fmt_e'(reg_req.wdata[`PULSE_FMT_LSB +: 2]);
        end
        `REG_AUX_SEL: begin
          q_nxt.aux_one_sel = reg_req.wdata[3:0];
          q_nxt.aux_two_sel = reg_req.wdata[7:4];
        end
        `REG_ENC_DIV_NUM: q_nxt.div_num = reg_req.wdata[15:0];
        `REG_ENC_DIV_DEN: q_nxt.div_den = reg_req.wdata[15:0];
        `REG_INPOS_WINDOW: q_nxt.inpos_win = reg_req.wdata[15:0];
        `REG_ROT_THRESH: q_nxt.rot_thresh = reg_req.wdata[15:0];
        default: q_nxt.rdata = q_r.rdata;
      endcase
    end
    q_nxt.rdata = 32'h0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `REG_MODE: q_nxt.rdata = {22'h0, q_r.stop_sel, 6'h0, q_r.main_power, q_r.speed_mode};
        `REG_GEAR_NUM_ONE: q_nxt.rdata = {16'h0, q_r.gear_one};
        `REG_GEAR_NUM_TWO: q_nxt.rdata = {16'h0, q_r.gear_two};
        `REG_PULSE_CFG: q_nxt.rdata = {28'h0, q_r.pulse_fmt, q_r.pulse_inh_en, q_r.pulse_src};
        `REG_AUX_SEL: q_nxt.rdata = {24'h0, q_r.aux_two_sel, q_r.aux_one_sel};
        `REG_ENC_DIV_NUM: q_nxt.rdata = {16'h0, q_r.div_num};
        `REG_ENC_DIV_DEN: q_nxt.rdata = {16'h0, q_r.div_den};
        `REG_INPOS_WINDOW: q_nxt.rdata = {16'h0, q_r.inpos_win};
        `REG_ROT_THRESH: q_nxt.rdata = {16'h0, q_r.rot_thresh};
        `REG_ALARM: q_nxt.rdata = q_r.alarms;
        `REG_STATUS: q_nxt.rdata = {22'h0, q_r.state, status};
        `REG_DEVIATION: q_nxt.rdata = q_r.deviation;
        `REG_SPEED: q_nxt.rdata = {29'h0, q_r.speed_sel};
        default: q_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= '0;
      q_r.state <= st_servo_off;
      q_r.pulse_fmt <= fmt_rev_fwd;
      q_r.gear_one <= `GEAR_NUM_RESET;
      q_r.gear_two <= `GEAR_NUM_RESET;
      q_r.div_num <= `ENC_DIV_RESET;
      q_r.div_den <= `ENC_DIV_RESET;
      q_r.inpos_win <= `INPOS_WINDOW_RESET;
      q_r.rot_thresh <= `ROT_THRESH_RESET;
      q_r.out.fault_out_n <= 1'b1;
      q_r.out.enc_a_neg <= 1'b1;
      q_r.out.enc_b_neg <= 1'b1;
      q_r.out.enc_z_neg <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign seq_out = q_r.out;
  assign preset_speed_sel = q_r.speed_sel;

endmodule
`default_nettype wire

/* File: tb/servo_io_props.sv */
// port-level checker for the servo sequence i/o block
// assumes it is bound to servo_sequence_io_control and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module servo_io_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched ports
  input wire servo_io_pkg::reg_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire servo_io_pkg::seq_in_s seq_in,
  input wire logic [31:0] alarm_src,
  input wire servo_io_pkg::seq_out_s seq_out
);
  import servo_io_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // register port
  property p_rdata_idle;
    !$past(reg_req.rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside its slot");

  // ==========================================================
  // sequence outputs
  property p_power_off;
    !seq_in.run_in [*8] |-> !seq_out.motor_power_en;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("motor powered with run input off");
  property p_sync_delay;
    $rose(seq_in.run_in) && !seq_out.motor_power_en |=> !seq_out.motor_power_en;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("run input reached power without synchroniser delay");
  property p_brake_power;
    $rose(seq_out.brake_release_out) |-> seq_out.motor_power_en;
  endproperty
  a_brake_power: assert property (p_brake_power)
    else $error("brake released without motor power");
  property p_ready_alarm;
    $rose(alarm_src[0]) |-> ##[1:4] !seq_out.servo_ready_out;
  endproperty
  a_ready_alarm: assert property (p_ready_alarm)
    else $error("ready stayed on after alarm");
  property p_fault_alarm;
    $rose(alarm_src[0]) |-> ##[1:4] !seq_out.fault_out_n;
  endproperty
  a_fault_alarm: assert property (p_fault_alarm)
    else $error("fault output not low after alarm");
  property p_perm_alarm;
    $rose(alarm_src[31]) |-> ##4 !seq_out.fault_out_n [*8];
  endproperty
  a_perm_alarm: assert property (p_perm_alarm)
    else $error("permanent alarm did not hold fault output");
  property p_enc_pairs;
    seq_out.enc_a_pos != seq_out.enc_a_neg && seq_out.enc_b_pos != seq_out.enc_b_neg
      && seq_out.enc_z_pos != seq_out.enc_z_neg;
  endproperty
  a_enc_pairs: assert property (p_enc_pairs)
    else $error("encoder differential pair not complementary");
endmodule

`default_nettype wire

/* File: tb/servo_host_model.sv */
// host position controller model driving the command pulse pins
// assumes the bench calls send and keeps the gear switch guard itself
`timescale 1ns/100ps
`default_nettype none

module servo_host_model (
  // clock
  input wire logic ref_clk,
  // command pulse pins
  output servo_io_pkg::pulse_in_s pulse_in
);
  import servo_io_pkg::*;
  initial pulse_in = '0;

  // ==========================================================
  // one pulse is four phases of four clocks so the filter sees each edge
  task automatic send(input int n, input logic [1:0] fmt, input logic src, input logic fwd);
    logic p;
    logic q;
    logic [1:0] lines;
    for (int i = 0; i < n; i++) begin
      for (int ph = 0; ph < 4; ph++) begin
        p = (ph == 1 || ph == 2);
        q = (ph == 2 || ph == 3);
        case (fmt)
          2'h0: lines = {!fwd & p, fwd & p};
          2'h1: lines = {p, fwd};
          default: lines = fwd ? {q, p} : {p, q};
        endcase
        @(posedge ref_clk);
        pulse_in <= src ? {lines, 2'b00} : {2'b00, lines};
        repeat (3) @(posedge ref_clk);
      end
    end
    @(posedge ref_clk);
    pulse_in <= '0;
    repeat (10) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

/* File: tb/servo_sequence_io_control_tb.sv */
// self-checking bench for the servo sequence i/o block
// assumes the host model, the checker and the design sources compile alongside
`include "servo_io_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module servo_sequence_io_control_tb;
  import servo_io_pkg::*;
  localparam int O_BRK = 15, O_RDY = 14, O_FLT = 13, O_INP = 12, O_ROT = 11;
  localparam int O_AX1 = 10, O_AX2 = 9, O_Z = 8, O_AP = 7, O_BP = 5, O_ZP = 3, O_PWR = 1, O_DB = 0;
  // scaled stand-in for the quiet time around a gear switch
  localparam int GEAR_GUARD = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_s reg_req = '0;
  logic [31:0] reg_rdata;
  seq_in_s seq_in = '0;
  pulse_in_s pulse_in;
  enc_in_s enc_in = '0;
  logic [31:0] alarm_src = 32'h0;
  logic [15:0] motor_speed = 16'h0;
  seq_out_s seq_out;
  logic [2:0] preset_speed_sel;
  logic [31:0] last_dev = 32'h0;
  int err_count = 0;
  int checked = 0;

  always #2 ref_clk = ~ref_clk;

  servo_sequence_io_control #(.ERR_CLEAR_CYC(8), .ALARM_RESET_CYC(16), .BRAKE_DELAY_CYC(4))
    i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .seq_in(seq_in), .pulse_in(pulse_in), .enc_in(enc_in), .alarm_src(alarm_src),
    .motor_speed(motor_speed), .seq_out(seq_out), .preset_speed_sel(preset_speed_sel));
  servo_host_model i_host (.ref_clk(ref_clk), .pulse_in(pulse_in));

  // ==========================================================
  // shared tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask
  // compares the size of the deviation change since the last call
  task automatic dev_step(input logic [31:0] exp, input string what);
    logic [31:0] v;
    logic [31:0] d;
    rd(`REG_DEVIATION, v);
    d = v - last_dev;
    if (d[31]) d = -d;
    last_dev = v;
    chk(what, d, exp);
  endtask
  task automatic wait_out(input int idx, input logic v, input int lim, input string what);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (seq_out[idx] !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(what, {31'h0, seq_out[idx]}, {31'h0, v});
    if (seq_out[idx] !== v) stop_test();
    @(posedge ref_clk);
  endtask
  task automatic hold_in(input int cyc);
    repeat (cyc) @(posedge ref_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wait_out(O_FLT, 1'b1, 2, "fault idle");
    rchk(`REG_GEAR_NUM_ONE, 32'h1, "gear one default");
    rchk(`REG_INPOS_WINDOW, 32'hA, "window default");
    rchk(`REG_ROT_THRESH, 32'h32, "threshold default");
    wr(4'hD, 32'hFFFF_FFFF);
    rchk(4'hD, 32'h0, "unmapped read");
    wr(`REG_ALARM, 32'hFFFF_FFFF);
    rchk(`REG_ALARM, 32'h0, "alarm read only");
  endtask
  task automatic t_servo_on();
    wr(`REG_MODE, 32'h102);
    wait_out(O_RDY, 1'b1, 20, "ready");
    seq_in.run_in <= 1'b1;
    wait_out(O_PWR, 1'b1, 20, "power on");
    wait_out(O_BRK, 1'b1, 30, "brake release");
  endtask
  task automatic t_pulses();
    wr(`REG_GEAR_NUM_ONE, 32'h3);
    wr(`REG_GEAR_NUM_TWO, 32'h5);
    wr(`REG_PULSE_CFG, 32'h0);
    seq_in.pulse_inhibit_in <= 1'b1;
    i_host.send(4, 2'h0, 1'b0, 1'b1);
    dev_step(32'd12, "source zero pulses");
    chk("not in position", {31'h0, seq_out.in_position_out}, 32'h0);
    i_host.send(4, 2'h0, 1'b1, 1'b1);
    dev_step(32'd0, "wrong source ignored");
    wr(`REG_PULSE_CFG, 32'h1);
    i_host.send(4, 2'h0, 1'b1, 1'b0);
    dev_step(32'd12, "source one pulses");
    wr(`REG_PULSE_CFG, 32'h5);
    i_host.send(2, 2'h1, 1'b1, 1'b1);
    dev_step(32'd6, "pulse and direction");
    wr(`REG_PULSE_CFG, 32'h9);
    i_host.send(1, 2'h2, 1'b1, 1'b1);
    dev_step(32'd12, "quadrature");
    seq_in.pulse_inhibit_in <= 1'b0;
    i_host.send(2, 2'h2, 1'b1, 1'b1);
    dev_step(32'd0, "inhibited");
    wr(`REG_PULSE_CFG, 32'hB);
    i_host.send(1, 2'h2, 1'b1, 1'b1);
    dev_step(32'd12, "inhibit disabled");
    seq_in.pulse_inhibit_in <= 1'b1;
    seq_in.position_error_clear_in <= 1'b1;
    hold_in(3);
    seq_in.position_error_clear_in <= 1'b0;
    hold_in(20);
    dev_step(32'd0, "short clear ignored");
    seq_in.position_error_clear_in <= 1'b1;
    hold_in(20);
    seq_in.position_error_clear_in <= 1'b0;
    hold_in(10);
    rchk(`REG_DEVIATION, 32'h0, "clear");
    last_dev = 32'h0;
    wait_out(O_INP, 1'b1, 10, "in position");
    hold_in(GEAR_GUARD);
    seq_in.gear_ratio_select_in <= 1'b1;
    hold_in(GEAR_GUARD);
    i_host.send(1, 2'h2, 1'b1, 1'b1);
    dev_step(32'd20, "gear two");
  endtask
  task automatic t_servo_off();
    seq_in.run_in <= 1'b0;
    wait_out(O_DB, 1'b1, 20, "dynamic brake");
    wait_out(O_PWR, 1'b0, 20, "power off");
    wait_out(O_BRK, 1'b0, 20, "brake engaged");
    rchk(`REG_DEVIATION, 32'd20, "kept with clear off");
  endtask
  task automatic t_alarm();
    wr(`REG_AUX_SEL, 32'h12);
    alarm_src <= 32'h1;
    hold_in(1);
    alarm_src <= 32'h0;
    wait_out(O_FLT, 1'b0, 10, "fault on alarm");
    wait_out(O_RDY, 1'b0, 10, "ready off on alarm");
    wait_out(O_AX1, 1'b1, 10, "aux one shows alarm");
    wait_out(O_AX2, 1'b0, 10, "aux two shows ready");
    rchk(`REG_ALARM, 32'h1, "alarm latched");
    seq_in.alarm_reset_in <= 1'b1;
    hold_in(4);
    seq_in.alarm_reset_in <= 1'b0;
    hold_in(30);
    chk("short reset ignored", {31'h0, seq_out.fault_out_n}, 32'h0);
    seq_in.alarm_reset_in <= 1'b1;
    hold_in(40);
    seq_in.alarm_reset_in <= 1'b0;
    wait_out(O_FLT, 1'b1, 20, "alarm reset");
    rchk(`REG_DEVIATION, 32'h0, "clear on alarm reset");
    alarm_src <= 32'h8000_0000;
    hold_in(1);
    alarm_src <= 32'h0;
    seq_in.alarm_reset_in <= 1'b1;
    hold_in(40);
    seq_in.alarm_reset_in <= 1'b0;
    hold_in(20);
    chk("permanent alarm", {31'h0, seq_out.fault_out_n}, 32'h0);
    resetn <= 1'b0;
    hold_in(3);
    resetn <= 1'b1;
    wait_out(O_FLT, 1'b1, 4, "fault after reset");
  endtask
  task automatic t_speed();
    wr(`REG_MODE, 32'h3);
    for (int i = 0; i < 8; i++) begin
      {seq_in.preset_speed_bit2_in, seq_in.preset_speed_bit1_in,
        seq_in.preset_speed_bit0_in} <= 3'(i);
      hold_in(10);
      chk("speed select", {29'h0, preset_speed_sel}, 32'(i));
    end
    motor_speed <= 16'h0033;
    wait_out(O_ROT, 1'b1, 10, "rotation on");
    motor_speed <= 16'h0032;
    wait_out(O_ROT, 1'b0, 10, "rotation off");
    enc_in.enc_a <= 1'b1;
    wait_out(O_AP, 1'b1, 20, "encoder a");
    enc_in.enc_b <= 1'b1;
    wait_out(O_BP, 1'b1, 20, "encoder b");
    enc_in.enc_z <= 1'b1;
    wait_out(O_Z, 1'b1, 20, "index out");
    wait_out(O_ZP, 1'b1, 4, "encoder z");
    enc_in.enc_z <= 1'b0;
    wait_out(O_Z, 1'b0, 20, "index ends");
  endtask

  initial begin
    hold_in(10);
    resetn <= 1'b1;
    t_reset();
    t_servo_on();
    t_pulses();
    t_servo_off();
    t_alarm();
    t_speed();
    stop_test();
  end
endmodule

bind servo_sequence_io_control servo_io_props i_props (
  .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .seq_in(seq_in), .alarm_src(alarm_src), .seq_out(seq_out));

`default_nettype wire
